// *** hw/tcw_pkg.sv ***
// tcw_pkg: constants, register map and carrier types for one timer
// channel in waveform mode; assumes a 32-bit AXI4-Lite register bus.
package tcw_pkg;

  // clock and prescaler
  localparam int MCK_PERIOD_NS = 40;
  localparam int PRESC_W = 10;
  localparam logic [3:0] DIV2_BIT = 4'h0;
  localparam logic [3:0] DIV8_BIT = 4'h2;
  localparam logic [3:0] DIV32_BIT = 4'h4;
  localparam logic [3:0] DIV128_BIT = 4'h6;
  localparam logic [3:0] DIV1024_BIT = 4'h9;

  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMPA = 8'h0C;
  localparam logic [7:0] OFS_CMPB = 8'h10;
  localparam logic [7:0] OFS_CMPC = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;

  // mode register fields
  localparam int F_CLKSEL = 0;
  localparam int F_INV = 3;
  localparam int F_GATE = 4;
  localparam int F_STOPC = 6;
  localparam int F_DISC = 7;
  localparam int F_EDGE = 8;
  localparam int F_SRC = 10;
  localparam int F_ETRG = 12;
  localparam int F_CTRG = 14;
  localparam int F_WAVE = 15;
  localparam int F_OUT_A_ON_COMPARE_A = 16;
  localparam int F_OUT_A_ON_COMPARE_C = 18;
  localparam int F_AEVT = 20;
  localparam int F_ASW = 22;
  localparam int F_OUT_B_ON_COMPARE_B = 24;
  localparam int F_OUT_B_ON_COMPARE_C = 26;
  localparam int F_BEVT = 28;
  localparam int F_BSW = 30;

  // control (command) register fields
  localparam int F_CLKEN = 0;
  localparam int F_CLKDIS = 1;
  localparam int F_SWTRG = 2;

  // status register fields
  localparam int F_CLKSTA = 16;
  localparam int F_MIRA = 17;
  localparam int F_MIRB = 18;

  // reset values
  localparam logic [31:0] RST_MODE = 32'h0000_0000;
  localparam logic [15:0] RST_CMP = 16'h0000;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // output effect codes
  localparam logic [1:0] EFF_SET = 2'h1;
  localparam logic [1:0] EFF_CLR = 2'h2;
  localparam logic [1:0] EFF_TGL = 2'h3;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } tcw_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } tcw_axi_rsp_t;

endpackage

// *** hw/tcw_channel.sv ***
// tcw_channel: one 16-bit timer channel driving two waveform pins,
// with its registers on AXI4-Lite. Assumes ext clock lines and the
// wave_out_b pin arrive asynchronously and are resynchronised here.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module tcw_channel (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // register bus
  input wire tcw_pkg::tcw_axi_req_t axi_req,
  output tcw_pkg::tcw_axi_rsp_t axi_rsp,
  // external clock lines 0..2
  input wire logic [2:0] ext_clock_line,
  // waveform pins
  output logic wave_out_a,
  output logic wave_out_a_oe,
  input wire logic wave_out_b_in,
  output logic wave_out_b,
  output logic wave_out_b_oe
);
  import tcw_pkg::*;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] stable;
    logic ev_prev;
    logic [PRESC_W-1:0] presc;
    logic clk_prev;
    logic [15:0] cnt;
    logic stepped;
    logic clk_on;
    logic clk_run;
    logic [31:0] mode;
    logic [15:0] ra;
    logic [15:0] rb;
    logic [15:0] rc;
    logic out_a;
    logic out_b;
    logic aw_ok;
    logic [7:0] aw_addr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcw_state_t;

  localparam tcw_state_t ST_RST = '{
    mode: RST_MODE, ra: RST_CMP, rb: RST_CMP, rc: RST_CMP,
    clk_run: 1'b1, default: '0};

  tcw_state_t st;
  tcw_state_t next_st;

  // apply one effect code to an output level
  function automatic logic apply_eff(input logic v, input logic [1:0] c);
    logic r;
    r = v;
    case (c)
      EFF_SET: r = 1'b1;
      EFF_CLR: r = 1'b0;
      EFF_TGL: r = ~v;
      default: r = v;
    endcase
    return r;
  endfunction

  // merge write data under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic wave;
  logic [2:0] clk_sel;
  logic src_pin;

  assign wave = st.mode[F_WAVE];
  assign clk_sel = st.mode[F_CLKSEL +: 3];
  assign src_pin = (st.mode[F_SRC +: 2] == 2'h0);

  ////////////////////////////////////////////////////////////////////
  // bus handshake outputs, stalled while frozen
  assign axi_rsp.awready = ce && !st.aw_ok && !st.bvalid;
  assign axi_rsp.wready = ce && !st.w_ok && !st.bvalid;
  assign axi_rsp.arready = ce && !st.rvalid;
  assign axi_rsp.bvalid = st.bvalid;
  assign axi_rsp.bresp = st.bresp;
  assign axi_rsp.rvalid = st.rvalid;
  assign axi_rsp.rdata = st.rdata;
  assign axi_rsp.rresp = st.rresp;

  // pins: drive only in waveform mode
  // waveform mode drive
  assign wave_out_a = st.out_a;
  assign wave_out_a_oe = wave;
  assign wave_out_b = st.out_b;
  assign wave_out_b_oe = wave && !src_pin;

  ////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic lvl;
    logic tick;
    logic ev_sig;
    logic evt;
    logic ma;
    logic mb;
    logic mc;
    logic wr_fire;
    logic [7:0] wa;
    logic [31:0] wd;
    logic sw_trg;
    logic c_en;
    logic c_dis;
    logic trig;
    logic [1:0] ef;
    lvl = 1'b0;
    ev_sig = 1'b0;
    ef = 2'h0;
    tick = 1'b0;
    evt = 1'b0;
    ma = 1'b0;
    mb = 1'b0;
    mc = 1'b0;
    wr_fire = 1'b0;
    wa = 8'h00;
    wd = 32'h0000_0000;
    sw_trg = 1'b0;
    c_en = 1'b0;
    c_dis = 1'b0;
    trig = 1'b0;
    next_st = st;

    // three-stage resync; a change counts once stages two and three agree
    next_st.s1 = {wave_out_b_in, ext_clock_line};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < 4; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.stable[i] = st.s3[i];
      end
    end

    // free-running prescaler
    next_st.presc = st.presc + 1'b1;

    case (clk_sel)
      3'h0: lvl = st.presc[DIV2_BIT];
      3'h1: lvl = st.presc[DIV8_BIT];
      3'h2: lvl = st.presc[DIV32_BIT];
      3'h3: lvl = st.presc[DIV128_BIT];
      3'h4: lvl = st.presc[DIV1024_BIT];
      3'h5: lvl = st.stable[0];
      3'h6: lvl = st.stable[1];
      3'h7: lvl = st.stable[2];
      default: lvl = 1'b0;
    endcase
    if (st.mode[F_GATE +: 2] != 2'h0) begin
      lvl = lvl & st.stable[st.mode[F_GATE +: 2] - 2'h1];
    end
    lvl = lvl ^ st.mode[F_INV];
    next_st.clk_prev = lvl;
    tick = lvl && !st.clk_prev;

    case (st.mode[F_SRC +: 2])
      2'h0: ev_sig = st.stable[3];
      2'h1: ev_sig = st.stable[0];
      2'h2: ev_sig = st.stable[1];
      default: ev_sig = st.stable[2];
    endcase
    next_st.ev_prev = ev_sig;
    case (st.mode[F_EDGE +: 2])
      2'h1: evt = ev_sig && !st.ev_prev;
      2'h2: evt = !ev_sig && st.ev_prev;
      2'h3: evt = ev_sig != st.ev_prev;
      default: evt = 1'b0;
    endcase

    // compare matches when the count has just stepped onto a value
    ma = st.stepped && (st.cnt == st.ra);
    mb = st.stepped && (st.cnt == st.rb);
    mc = st.stepped && (st.cnt == st.rc);

    // bus write channels
    if (axi_req.awvalid && axi_rsp.awready) begin
      next_st.aw_ok = 1'b1;
      next_st.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      next_st.w_ok = 1'b1;
      next_st.wdata = axi_req.wdata;
      next_st.wstrb = axi_req.wstrb;
    end
    if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end
    wr_fire = st.aw_ok && st.w_ok && !st.bvalid;
    wa = {st.aw_addr[7:2], 2'h0};
    wd = st.wdata;
    sw_trg = 1'b0;
    c_en = 1'b0;
    c_dis = 1'b0;
    if (wr_fire) begin
      next_st.aw_ok = 1'b0;
      next_st.w_ok = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      case (wa)
        OFS_MODE: next_st.mode = merge(st.mode, wd, st.wstrb);
        OFS_CTRL: begin
          if (st.wstrb[0]) begin
            c_en = wd[F_CLKEN];
            c_dis = wd[F_CLKDIS];
            sw_trg = wd[F_SWTRG];
          end
        end
        OFS_COUNT: next_st.bresp = RESP_OKAY;
        OFS_CMPA: begin
          if (wave) begin
            next_st.ra = 16'(merge({16'h0000, st.ra}, wd, st.wstrb));
          end
        end
        OFS_CMPB: begin
          if (wave) begin
            next_st.rb = 16'(merge({16'h0000, st.rb}, wd, st.wstrb));
          end
        end
        OFS_CMPC: next_st.rc = 16'(merge({16'h0000, st.rc}, wd, st.wstrb));
        OFS_STAT: next_st.bresp = RESP_OKAY;
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end

    trig = sw_trg || (evt && st.mode[F_ETRG])
      || (mc && st.mode[F_CTRG]);

    // clock enable state: disable beats enable
    if (c_en && !c_dis) begin
      next_st.clk_on = 1'b1;
    end
    if (c_dis) begin
      next_st.clk_on = 1'b0;
    end
    if (mc && st.mode[F_DISC]) begin
      next_st.clk_on = 1'b0;
    end
    if (mc && st.mode[F_STOPC]) begin
      next_st.clk_run = 1'b0;
    end
    if (trig) begin
      next_st.clk_run = 1'b1;
    end

    // counter
    next_st.stepped = 1'b0;
    if (trig) begin
      next_st.cnt = 16'h0000;
    end else if (st.clk_on && st.clk_run && tick) begin
      next_st.cnt = st.cnt + 16'h0001;
      next_st.stepped = 1'b1;
    end

    // waveform effects, later events take priority
    if (wave) begin
      if (ma) begin
        next_st.out_a = apply_eff(next_st.out_a, st.mode[F_OUT_A_ON_COMPARE_A +: 2]);
      end
      if (mc) begin
        next_st.out_a = apply_eff(next_st.out_a, st.mode[F_OUT_A_ON_COMPARE_C +: 2]);
      end
      if (evt) begin
        next_st.out_a = apply_eff(next_st.out_a, st.mode[F_AEVT +: 2]);
      end
      if (sw_trg) begin
        next_st.out_a = apply_eff(next_st.out_a, st.mode[F_ASW +: 2]);
      end
      if (!src_pin) begin
        ef = mb ? st.mode[F_OUT_B_ON_COMPARE_B +: 2] : 2'h0;
        next_st.out_b = apply_eff(next_st.out_b, ef);
        ef = mc ? st.mode[F_OUT_B_ON_COMPARE_C +: 2] : 2'h0;
        next_st.out_b = apply_eff(next_st.out_b, ef);
        ef = evt ? st.mode[F_BEVT +: 2] : 2'h0;
        next_st.out_b = apply_eff(next_st.out_b, ef);
        ef = sw_trg ? st.mode[F_BSW +: 2] : 2'h0;
        next_st.out_b = apply_eff(next_st.out_b, ef);
      end
    end

    // bus read channel
    if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      case ({axi_req.araddr[7:2], 2'h0})
        OFS_MODE: next_st.rdata = st.mode;
        OFS_CTRL: next_st.rdata = 32'h0000_0000;
        OFS_COUNT: next_st.rdata = {16'h0000, st.cnt};
        OFS_CMPA: next_st.rdata = {16'h0000, st.ra};
        OFS_CMPB: next_st.rdata = {16'h0000, st.rb};
        OFS_CMPC: next_st.rdata = {16'h0000, st.rc};
        OFS_STAT: begin
          next_st.rdata[F_CLKSTA] = st.clk_on;
          next_st.rdata[F_MIRA] = st.out_a;
          next_st.rdata[F_MIRB] = src_pin ? st.stable[3] : st.out_b;
        end
        default: next_st.rresp = RESP_SLVERR;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= ST_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

endmodule

`default_nettype wire

// *** tb/tcw_pins.sv ***
// tcw_pins: outside world at the pins of tcw_channel
// assumes the bench sets the levels that the far side drives
`timescale 1ns/1ns
`default_nettype none

module tcw_pins (
  // levels from the far side
  input wire logic [2:0] ext_drv,
  input wire logic b_drv,
  // design side of the pad
  input wire logic wave_out_b,
  input wire logic wave_out_b_oe,
  output logic [2:0] ext_clock_line,
  output logic wave_out_b_in
);
  // external lines pass straight through
  assign ext_clock_line = ext_drv;
  assign wave_out_b_in = wave_out_b_oe ? wave_out_b : b_drv;
endmodule

`default_nettype wire

// *** tb/tcw_channel_props.sv ***
// tcw_channel_props: port checks for tcw_channel
// assumes one clock domain and a bind at the foot of the file
`timescale 1ns/1ns
`default_nettype none

module tcw_channel_props (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // register bus
  input wire tcw_pkg::tcw_axi_req_t axi_req,
  input wire tcw_pkg::tcw_axi_rsp_t axi_rsp,
  // pins
  input wire logic wave_out_a,
  input wire logic wave_out_a_oe,
  input wire logic wave_out_b,
  input wire logic wave_out_b_oe
);
  import tcw_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // bus answers stand until taken
  property p_bhold;
    axi_rsp.bvalid && !axi_req.bready |=>
      axi_rsp.bvalid && $stable(axi_rsp.bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rhold;
    axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  // refusals while busy or frozen; read answer the cycle after ar is taken
  property p_arblk;
    axi_rsp.rvalid |-> !axi_rsp.arready;
  endproperty
  a_arblk: assert property (p_arblk) else $error("ar taken early");
  property p_awblk;
    axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
  endproperty
  a_awblk: assert property (p_awblk) else $error("aw taken early");
  property p_cefrz;
    !ce |-> !(axi_rsp.awready || axi_rsp.wready || axi_rsp.arready);
  endproperty
  a_cefrz: assert property (p_cefrz) else $error("ready with ce low");
  property p_rlat;
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("late read answer");
  // pad enables and frozen outputs
  property p_oeb;
    wave_out_b_oe |-> wave_out_a_oe;
  endproperty
  a_oeb: assert property (p_oeb) else $error("b driven");
  property p_capa;
    !wave_out_a_oe && !$past(wave_out_a_oe) |-> $stable(wave_out_a);
  endproperty
  a_capa: assert property (p_capa) else $error("a moved");
  property p_srcb;
    !wave_out_b_oe && !$past(wave_out_b_oe) |-> $stable(wave_out_b);
  endproperty
  a_srcb: assert property (p_srcb) else $error("b moved");
  // main scenarios
  c_arise: cover property ($rose(wave_out_a));
  c_brise: cover property ($rose(wave_out_b));
  c_err: cover property (axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR);
endmodule

bind tcw_channel tcw_channel_props u_props (
  .aclk(aclk), .aresetn(aresetn), .ce(ce),
  .axi_req(axi_req), .axi_rsp(axi_rsp),
  .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe),
  .wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe)
);

`default_nettype wire

// *** tb/timer_channel_waveform_mode_bench.sv ***
// bench for tcw_channel: bus tasks and directed tests
// assumes tcw_pins at the pins and the checker bound by its own file
`timescale 1ns/1ns
`default_nettype none

module timer_channel_waveform_mode_bench;
  import tcw_pkg::*;
  logic aclk, aresetn, ce, b_drv;
  logic [2:0] ext_drv, ext_clock_line;
  logic wave_out_a, wave_out_a_oe, wave_out_b_in;
  logic wave_out_b, wave_out_b_oe;
  tcw_axi_req_t req;
  tcw_axi_rsp_t rsp;
  int failures, samples_checked, cycles;
  logic [31:0] d, c1, m;
  logic [1:0] r;
  logic [1:0] cd [4] = '{EFF_SET, EFF_CLR, EFF_TGL, 2'h0};
  logic ex [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  tcw_channel DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .axi_req(req), .axi_rsp(rsp), .ext_clock_line(ext_clock_line),
    .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe),
    .wave_out_b_in(wave_out_b_in), .wave_out_b(wave_out_b),
    .wave_out_b_oe(wave_out_b_oe));
  tcw_pins PIN (.ext_drv(ext_drv), .b_drv(b_drv),
    .wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe),
    .ext_clock_line(ext_clock_line), .wave_out_b_in(wave_out_b_in));

  ////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////
  // compare and report
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  // closing report
  task stop_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // axi write: aw and w together, wait for b
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= v;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
  endtask
  // axi read: wait for r
  task rd(input logic [7:0] a, output logic [31:0] v,
          output logic [1:0] rs);
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    v = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  // read and compare
  task rc(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(n, d, e);
  endtask

  ////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    req = '0;
    req.wstrb = 4'hF;
    ce = 1'b1;
    aresetn = 1'b0;
    ext_drv = 3'h0;
    b_drv = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and unmapped place
    rc("mode", OFS_MODE, RST_MODE);
    rc("cmpa", OFS_CMPA, 32'h0);
    rc("count", OFS_COUNT, 32'h0);
    rd(8'h1C, d, r);
    chk("unmapped", r, RESP_SLVERR);
    $display("test reset done");
    // compare registers by mode
    wr(OFS_CMPA, 32'h1234);
    rc("cmpa capture", OFS_CMPA, 32'h0);
    m = 32'h1 << F_WAVE;
    wr(OFS_MODE, m);
    chk("oe a", wave_out_a_oe, 1'b1);
    wr(OFS_CMPA, 32'h1234);
    wr(OFS_CMPB, 32'hABCD);
    rc("cmpa wave", OFS_CMPA, 32'h1234);
    rc("cmpb wave", OFS_CMPB, 32'hABCD);
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    ce <= 1'b1;
    $display("test compare regs done");
    // software trigger effects, every code
    m = m | (32'h1 << F_SRC);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_MODE, m | (32'(cd[i]) << F_ASW) | (32'(cd[i]) << F_BSW));
      wr(OFS_CTRL, 32'h4);
      repeat (3) @(posedge aclk);
      chk("out a sw", wave_out_a, ex[i]);
      chk("out b sw", wave_out_b, ex[i]);
    end
    chk("oe b out", wave_out_b_oe, 1'b1);
    wr(OFS_MODE, 32'h1 << F_WAVE);
    chk("oe b in", wave_out_b_oe, 1'b0);
    repeat (6) @(posedge aclk);
    rc("status pin low", OFS_STAT, 32'h0002_0000);
    b_drv <= 1'b1;
    repeat (6) @(posedge aclk);
    rc("status pin high", OFS_STAT, 32'h0006_0000);
    $display("test soft trigger done");
    // mid-run reset, then stop at compare c
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk("oe a rst", wave_out_a_oe, 1'b0);
    chk("out a rst", wave_out_a, 1'b0);
    m = (32'h1 << F_WAVE) | (32'h1 << F_STOPC) | 32'h1;
    wr(OFS_CMPC, 32'h10);
    wr(OFS_MODE, m | (32'(EFF_SET) << F_OUT_A_ON_COMPARE_C));
    wr(OFS_CTRL, 32'h5);
    repeat (300) @(posedge aclk);
    rc("stop count", OFS_COUNT, 32'h10);
    chk("out a cmpc", wave_out_a, 1'b1);
    $display("test stop done");
    // rising event on line 0 restarts the count
    m = (32'h1 << F_WAVE) | (32'h1 << F_SRC) | 32'h1 | (32'h1 << F_EDGE);
    wr(OFS_MODE, m | (32'h1 << F_ETRG) | (32'(EFF_CLR) << F_AEVT)
      | (32'(EFF_SET) << F_BEVT));
    ext_drv <= 3'h7;
    repeat (40) @(posedge aclk);
    chk("out a evt", wave_out_a, 1'b0);
    chk("out b evt", wave_out_b, 1'b1);
    rd(OFS_COUNT, c1, r);
    chk("evt restart", c1 < 32'h10, 1'b1);
    repeat (80) @(posedge aclk);
    rd(OFS_COUNT, d, r);
    chk("live count", d > c1, 1'b1);
    $display("test event done");
    // compare effects at div2, stop and disable at compare c
    wr(OFS_CMPA, 32'h2);
    wr(OFS_CMPB, 32'h4);
    wr(OFS_CMPC, 32'h8);
    m = (32'h1 << F_WAVE) | (32'h1 << F_SRC);
    wr(OFS_MODE, m | (32'h3 << F_STOPC) | (32'(EFF_SET) << F_OUT_A_ON_COMPARE_A)
      | (32'(EFF_CLR) << F_OUT_B_ON_COMPARE_B) | (32'(EFF_TGL) << F_OUT_B_ON_COMPARE_C));
    wr(OFS_CTRL, 32'h5);
    repeat (40) @(posedge aclk);
    rc("div2 stop", OFS_COUNT, 32'h8);
    chk("out a cmpa", wave_out_a, 1'b1);
    chk("out b cmpb", wave_out_b, 1'b1);
    chk("out b cmpc", wave_out_b, 1'b1);
    rc("disabled", OFS_STAT, 32'h0006_0000);
    $display("test compare effects done");
    // compare c trigger keeps the count at or below compare c
    wr(OFS_MODE, m | (32'h1 << F_CTRG));
    wr(OFS_CTRL, 32'h5);
    repeat (100) @(posedge aclk);
    rd(OFS_COUNT, d, r);
    chk("cmpc restart", d < 32'h9, 1'b1);
    $display("test compare trigger done");
    // gated, inverted line 0 clock; falling event on line 1
    wr(OFS_MODE, (32'h1 << F_WAVE) | 32'h5 | (32'h1 << F_INV)
      | (32'h3 << F_GATE) | (32'h2 << F_EDGE) | (32'h2 << F_SRC)
      | (32'(EFF_TGL) << F_AEVT));
    ext_drv <= 3'h3;
    repeat (8) @(posedge aclk);
    rd(OFS_COUNT, c1, r);
    ext_drv <= 3'h2;
    repeat (8) @(posedge aclk);
    ext_drv <= 3'h3;
    repeat (8) @(posedge aclk);
    rc("gated", OFS_COUNT, c1);
    ext_drv <= 3'h7;
    repeat (8) @(posedge aclk);
    rc("inverted hold", OFS_COUNT, c1);
    ext_drv <= 3'h6;
    repeat (8) @(posedge aclk);
    rc("inverted step", OFS_COUNT, c1 + 32'h1);
    ext_drv <= 3'h4;
    repeat (8) @(posedge aclk);
    chk("out a fall", wave_out_a, 1'b0);
    chk("out b kept", wave_out_b, 1'b1);
    rc("no restart", OFS_COUNT, c1 + 32'h1);
    ext_drv <= 3'h6;
    repeat (8) @(posedge aclk);
    chk("no rise evt", wave_out_a, 1'b0);
    $display("test clock shaping done");
    stop_test();
  end
endmodule

`default_nettype wire
